// File: hdl/sapseq_pkg.sv
package sapseq_pkg;
  localparam int DATA_W  = 14;
  localparam int BUS_W   = 8;
  localparam int GAIN_W  = 6;
  localparam int OFFS_W  = 8;
  localparam int COLOURS = 3;
  localparam int UPPER_LO = 6;
  localparam int LOWER_W  = 6;
  localparam logic [1:0] CFG_SENSOR_DC = 2'h0;
  localparam logic [1:0] CFG_SENSOR_AC = 2'h1;
  localparam logic [1:0] CFG_CCD       = 2'h2;
  localparam logic [1:0] CFG_ROTATE    = 2'h3;
  localparam logic [1:0] CFG_RST       = CFG_SENSOR_DC;
  localparam logic [GAIN_W-1:0] GAIN_RST = 6'h00;
  localparam logic [OFFS_W-1:0] OFFS_RST = 8'h00;
  localparam logic [1:0] COLOUR_RED  = 2'h0;
  localparam logic [1:0] COLOUR_LAST = 2'h2;
  localparam logic [1:0] BUF_FULL    = 2'h2;
  localparam logic [1:0] LOWER_PAD   = 2'h0;
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b01,
    PH_UPPER = 2'b10
  } sapseq_phase_t;
endpackage

// File: hdl/sapseq_top.sv
`timescale 1ns/10ps
// Behaviour
// - falling conversion clock: sample pixel, start next track, drive upper half
// - rising conversion clock: drive lower half, two bus transfers per pixel
// - converter tracks while conversion clock high, holds and converts while low
// - AC-coupled sensor mode: clamp strobe high ties coupling capacitor to ground
// - CCD mode: clamp strobe high ties coupling capacitor to top ladder reference
// - clamp strobe low: release clamp, sample video against stored black level
// - CCD mode inverts the result so zero input gives zero code
// - DC-coupled mode: zero input gives zero code, referenced to bottom ladder
// - coupling mode chosen only by control registers the host loads
// - external reference mode with internal sensor reference bit clear subtracts external reference, keeps offset trim
// - internal sensor reference bit turns reference pin into bias output
// - rotating mode steps to next colour's gain and offset every line after the first, which stays on red
// - power-up: DC-coupled sensor, internal references, red, unity gain, zero offset
module sapseq_top (
  input  wire logic                             core_clk,
  input  wire logic                             srst,
  input  wire logic                             conversion_clock,
  input  wire logic                             clamp_strobe,
  input  wire logic                             line_sync,
  input  wire logic                             cfg_load,
  input  wire logic                             config_select_high,
  input  wire logic                             config_select_low,
  input  wire logic                             internal_sensor_ref_select,
  input  wire logic                             external_ref_select,
  input  wire logic                             preload_we,
  input  wire logic [1:0]                       preload_colour,
  input  wire logic [sapseq_pkg::GAIN_W-1:0]    preload_gain,
  input  wire logic [sapseq_pkg::OFFS_W-1:0]    preload_offset,
  input  wire logic [sapseq_pkg::DATA_W-1:0]    conv_result,
  input  wire logic                             conv_valid,
  output logic                                  conv_ready,
  input  wire logic                             bus_ready,
  output logic [sapseq_pkg::BUS_W-1:0]          data_bus,
  output logic                                  data_bus_oe_n,
  output logic                                  bus_upper,
  output logic                                  bus_lower,
  output logic                                  adc_track,
  output logic                                  pga_next,
  output logic                                  clamp_to_ground,
  output logic                                  clamp_to_top_ref,
  output logic                                  video_track,
  output logic                                  black_ref_stored,
  output logic                                  bottom_ref_input,
  output logic                                  ext_ref_subtract,
  output logic                                  ext_ref_bias_drive,
  output logic [1:0]                            colour,
  output logic [sapseq_pkg::GAIN_W-1:0]         active_gain,
  output logic [sapseq_pkg::OFFS_W-1:0]         active_offset
);

  typedef struct packed {
    logic [1:0]                                          cfg;
    logic                                                int_ref;
    logic                                                ext_ref;
    logic [sapseq_pkg::COLOURS-1:0][sapseq_pkg::GAIN_W-1:0] gain;
    logic [sapseq_pkg::COLOURS-1:0][sapseq_pkg::OFFS_W-1:0] offs;
    logic [1:0]                                          colour;
    logic                                                first;
    logic                                                ck;
    logic                                                clp;
    logic                                                sync;
    logic [1:0][sapseq_pkg::DATA_W-1:0]                  buff;
    logic                                                wptr;
    logic                                                rptr;
    logic [1:0]                                          cnt;
    logic [sapseq_pkg::LOWER_W-1:0]                      lower;
    sapseq_pkg::sapseq_phase_t                           phase;
    logic [sapseq_pkg::BUS_W-1:0]                        bus;
    logic                                                oe_n;
    logic                                                upper_p;
    logic                                                lower_p;
    logic                                                track;
    logic                                                pga_p;
    logic                                                clamp_gnd;
    logic                                                clamp_top;
    logic                                                video;
    logic                                                black_p;
    logic                                                bottom_ref;
    logic                                                ext_sub;
    logic                                                bias;
    logic [sapseq_pkg::GAIN_W-1:0]                       act_gain;
    logic [sapseq_pkg::OFFS_W-1:0]                       act_offs;
    logic                                                rdy;
  } sapseq_state_t;

  sapseq_state_t q;
  sapseq_state_t d;
  logic          ck_fall;
  logic          ck_rise;
  logic          line_start;
  logic          push;
  logic          pop;
  logic [sapseq_pkg::DATA_W-1:0] head_word;
  logic [1:0]    cfg_new;

  function automatic logic [1:0] next_colour(input logic [1:0] c);
    next_colour = (c == sapseq_pkg::COLOUR_LAST) ? sapseq_pkg::COLOUR_RED : c + 2'h1;
  endfunction

  function automatic logic clamp_mode(input logic [1:0] c);
    clamp_mode = (c == sapseq_pkg::CFG_SENSOR_AC) || (c == sapseq_pkg::CFG_CCD);
  endfunction

  always_comb begin
    d          = q;
    ck_fall    = q.ck & ~conversion_clock;
    ck_rise    = ~q.ck & conversion_clock;
    line_start = line_sync & ~q.sync;
    head_word  = q.buff[q.rptr];
    cfg_new    = {config_select_high, config_select_low};
    d.ck       = conversion_clock;
    d.clp      = clamp_strobe;
    d.sync     = line_sync;
    // per-colour preload from the host
    if (preload_we && preload_colour <= sapseq_pkg::COLOUR_LAST) begin
      d.gain[preload_colour] = preload_gain;
      d.offs[preload_colour] = preload_offset;
    end
    // line-by-line rotation
    if (q.cfg == sapseq_pkg::CFG_ROTATE && line_start) begin
      if (q.first) begin
        d.first = 1'b0;
      end else begin
        d.colour = next_colour(q.colour);
      end
    end
    // configuration load, only path that changes coupling mode
    if (cfg_load) begin
      d.cfg     = cfg_new;
      d.int_ref = internal_sensor_ref_select;
      d.ext_ref = external_ref_select;
      if (cfg_new == sapseq_pkg::CFG_ROTATE && q.cfg != sapseq_pkg::CFG_ROTATE) begin
        d.colour = sapseq_pkg::COLOUR_RED;
        d.first  = 1'b1;
      end
    end
    d.act_gain   = q.gain[q.colour];
    d.act_offs   = q.offs[q.colour];
    d.ext_sub    = q.ext_ref & ~q.int_ref;
    d.bias       = q.int_ref;
    d.bottom_ref = ~clamp_mode(q.cfg);
    d.track      = conversion_clock;
    d.pga_p      = ck_fall;
    d.clamp_gnd  = clamp_strobe & (q.cfg == sapseq_pkg::CFG_SENSOR_AC);
    d.clamp_top  = clamp_strobe & (q.cfg == sapseq_pkg::CFG_CCD);
    d.video      = ~clamp_strobe;
    d.black_p    = q.clp & ~clamp_strobe & clamp_mode(q.cfg);
    d.oe_n       = line_sync;
    d.upper_p    = 1'b0;
    d.lower_p    = 1'b0;
    // two-entry buffer between converter and bus
    push = ck_fall & conv_valid & (q.cnt != sapseq_pkg::BUF_FULL);
    pop  = ck_fall & bus_ready & (q.cnt != 2'h0);
    if (push) begin
      if (q.cfg == sapseq_pkg::CFG_CCD) begin
        d.buff[q.wptr] = ~conv_result;
      end else begin
        d.buff[q.wptr] = conv_result;
      end
      d.wptr = ~q.wptr;
    end
    if (pop) begin
      d.rptr = ~q.rptr;
    end
    d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
    d.rdy = (d.cnt != sapseq_pkg::BUF_FULL);
    // bus halves
    case (q.phase)
      sapseq_pkg::PH_IDLE: begin
        if (pop) begin
          d.bus     = head_word[sapseq_pkg::DATA_W-1:sapseq_pkg::UPPER_LO];
          d.lower   = head_word[sapseq_pkg::LOWER_W-1:0];
          d.upper_p = 1'b1;
          d.phase   = sapseq_pkg::PH_UPPER;
        end
      end
      sapseq_pkg::PH_UPPER: begin
        if (ck_rise) begin
          d.bus     = {q.lower, sapseq_pkg::LOWER_PAD};
          d.lower_p = 1'b1;
          d.phase   = sapseq_pkg::PH_IDLE;
        end
      end
      default: begin
        d.phase = sapseq_pkg::PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q            <= '0;
      q.cfg        <= sapseq_pkg::CFG_RST;
      q.gain       <= {sapseq_pkg::COLOURS{sapseq_pkg::GAIN_RST}};
      q.offs       <= {sapseq_pkg::COLOURS{sapseq_pkg::OFFS_RST}};
      q.colour     <= sapseq_pkg::COLOUR_RED;
      q.act_gain   <= sapseq_pkg::GAIN_RST;
      q.act_offs   <= sapseq_pkg::OFFS_RST;
      q.phase      <= sapseq_pkg::PH_IDLE;
      q.oe_n       <= 1'b1;
      q.video      <= 1'b1;
      q.bottom_ref <= 1'b1;
      q.rdy        <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign conv_ready         = q.rdy;
  assign data_bus           = q.bus;
  assign data_bus_oe_n      = q.oe_n;
  assign bus_upper          = q.upper_p;
  assign bus_lower          = q.lower_p;
  assign adc_track          = q.track;
  assign pga_next           = q.pga_p;
  assign clamp_to_ground    = q.clamp_gnd;
  assign clamp_to_top_ref   = q.clamp_top;
  assign video_track        = q.video;
  assign black_ref_stored   = q.black_p;
  assign bottom_ref_input   = q.bottom_ref;
  assign ext_ref_subtract   = q.ext_sub;
  assign ext_ref_bias_drive = q.bias;
  assign colour             = q.colour;
  assign active_gain        = q.act_gain;
  assign active_offset      = q.act_offs;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence upper_sent;
    bus_upper && q.phase == sapseq_pkg::PH_UPPER;
  endsequence
  sequence lower_sent;
    bus_lower && data_bus[1:0] == sapseq_pkg::LOWER_PAD;
  endsequence
  sequence pixel_taken;
    ck_fall && conv_valid && conv_ready;
  endsequence
  sequence pixel_held;
    !bus_ready;
  endsequence

  upper_half_out_a : assert property (pop |=> upper_sent ##0
    data_bus == $past(head_word[sapseq_pkg::DATA_W-1:sapseq_pkg::UPPER_LO]))
    else $error("upper half not driven on falling edge");
  lower_half_out_a : assert property (ck_rise && q.phase == sapseq_pkg::PH_UPPER
    |=> lower_sent ##0 data_bus[sapseq_pkg::BUS_W-1:2] == $past(q.lower))
    else $error("lower half not driven on rising edge");
  halves_apart_a : assert property (bus_upper |-> !bus_lower)
    else $error("both bus halves flagged at once");
  track_hold_a : assert property (ck_fall |=> !adc_track && pga_next)
    else $error("converter track state wrong");
  track_rise_a : assert property (ck_rise |=> adc_track && !pga_next)
    else $error("converter not tracking while clock high");
  pga_pulse_a : assert property (!ck_fall |=> !pga_next)
    else $error("next pixel strobe without falling edge");
  pixel_take_a : assert property (pixel_taken ##0 pixel_held
    |=> pga_next && q.cnt == $past(q.cnt) + 2'h1)
    else $error("converter word not buffered");
  full_stall_a : assert property (!conv_ready && !pop |=> !conv_ready && $stable(q.cnt))
    else $error("full buffer changed without pop");
  ground_clamp_a : assert property (clamp_strobe && q.cfg == sapseq_pkg::CFG_SENSOR_AC
    |=> clamp_to_ground && !clamp_to_top_ref)
    else $error("ground clamp not closed");
  clamp_open_a : assert property (!clamp_strobe |=> !clamp_to_ground && !clamp_to_top_ref)
    else $error("clamp closed without strobe");
  top_clamp_a : assert property (clamp_strobe && q.cfg == sapseq_pkg::CFG_CCD
    |=> clamp_to_top_ref && !clamp_to_ground)
    else $error("top reference clamp not closed");
  clamp_release_a : assert property ($fell(clamp_strobe)
    |=> !clamp_to_ground && !clamp_to_top_ref && video_track)
    else $error("clamp not released");
  black_store_a : assert property ($fell(clamp_strobe) && !$past(srst) && clamp_mode(q.cfg)
    |=> black_ref_stored)
    else $error("black level not stored");
  video_hold_a : assert property (clamp_strobe |=> !video_track)
    else $error("video tracked during clamp");
  ccd_invert_a : assert property (push && q.cfg == sapseq_pkg::CFG_CCD
    |=> q.buff[$past(q.wptr)] == ~$past(conv_result))
    else $error("ccd result not inverted");
  plain_store_a : assert property (push && q.cfg != sapseq_pkg::CFG_CCD
    |=> q.buff[$past(q.wptr)] == $past(conv_result))
    else $error("sensor result altered");
  dc_zero_a : assert property (push && q.cfg == sapseq_pkg::CFG_SENSOR_DC
    && conv_result == 14'h0000 |=> q.buff[$past(q.wptr)] == 14'h0000 && bottom_ref_input)
    else $error("dc zero input not zero code");
  dc_bottom_a : assert property (q.cfg == sapseq_pkg::CFG_SENSOR_DC |=> bottom_ref_input)
    else $error("dc mode not on bottom reference");
  ac_no_bottom_a : assert property (clamp_mode(q.cfg) |=> !bottom_ref_input)
    else $error("coupled mode on bottom reference");
  cfg_only_load_a : assert property (!cfg_load |=> $stable(q.cfg))
    else $error("configuration changed without load");
  ext_subtract_a : assert property (q.ext_ref && !q.int_ref
    |=> ext_ref_subtract ##1 active_offset == $past(q.offs[q.colour]))
    else $error("external reference subtraction wrong");
  bias_drive_a : assert property (q.int_ref |=> ext_ref_bias_drive && !ext_ref_subtract)
    else $error("bias output not driven");
  rotate_step_a : assert property (q.cfg == sapseq_pkg::CFG_ROTATE && line_start
    && !q.first && !cfg_load |=> colour == next_colour($past(colour)))
    else $error("colour did not rotate");
  first_line_a : assert property (q.cfg == sapseq_pkg::CFG_ROTATE && line_start
    && q.first && !cfg_load |=> $stable(colour) && !q.first)
    else $error("first line advanced colour");
  colour_hold_a : assert property (q.cfg != sapseq_pkg::CFG_ROTATE && !cfg_load
    |=> $stable(colour))
    else $error("colour moved outside rotation");
  gain_follow_a : assert property (1'b1 |=> active_gain == $past(q.gain[q.colour])
    && active_offset == $past(q.offs[q.colour]))
    else $error("active gain or offset stale");
  rotate_restart_a : assert property (cfg_load && cfg_new == sapseq_pkg::CFG_ROTATE
    && q.cfg != sapseq_pkg::CFG_ROTATE
    |=> colour == sapseq_pkg::COLOUR_RED && q.first)
    else $error("rotation did not restart");
  reset_state_a : assert property ($past(srst)
    |-> q.cfg == sapseq_pkg::CFG_RST && active_gain == sapseq_pkg::GAIN_RST
    && colour == sapseq_pkg::COLOUR_RED && !ext_ref_bias_drive)
    else $error("reset state wrong");

endmodule // sapseq_top

// File: bench/sapseq_rx_model.sv
`timescale 1ns/10ps
// far-side demultiplexer: joins upper and lower halves, ready prompt, random or stalled
module sapseq_rx_model (
  input  wire logic                         core_clk,
  input  wire logic                         srst,
  input  wire logic [1:0]                   slow,
  input  wire logic [sapseq_pkg::BUS_W-1:0] data_bus,
  input  wire logic                         data_bus_oe_n,
  input  wire logic                         bus_upper,
  input  wire logic                         bus_lower,
  output logic                              bus_ready,
  output logic [sapseq_pkg::DATA_W-1:0]     word,
  output logic [1:0]                        pad,
  output logic                              word_stb
);
  logic [sapseq_pkg::BUS_W-1:0] upper_q = 8'h00;
  initial begin
    bus_ready = 1'b1;
    word_stb = 1'b0;
  end
  always @(posedge core_clk) begin
    bus_ready <= (slow == 2'h0) ? 1'b1 : (slow == 2'h1) ? 1'($urandom % 2) : 1'b0;
    word_stb <= 1'b0;
    if (!srst && !data_bus_oe_n && bus_upper) begin
      upper_q <= data_bus;
    end
    if (!srst && !data_bus_oe_n && bus_lower) begin
      word <= {upper_q, data_bus[7:2]};
      pad <= data_bus[1:0];
      word_stb <= 1'b1;
    end
  end
endmodule // sapseq_rx_model

// File: bench/sensor_adc_pixel_sequencer_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
  $display("FAIL %0t got %0h exp %0h", $time, (a), (b)); end end
module sensor_adc_pixel_sequencer_tb;
  logic        core_clk = 1'b0, srst = 1'b1, conversion_clock = 1'b0, clamp_strobe = 1'b0;
  logic        line_sync = 1'b0, cfg_load = 1'b0, config_select_high = 1'b0;
  logic        config_select_low = 1'b0, internal_sensor_ref_select = 1'b0;
  logic        external_ref_select = 1'b0, preload_we = 1'b0, conv_valid = 1'b0;
  logic [1:0]  preload_colour = 2'h0, slow = 2'h0, colour, pad, mode_m = 2'h0;
  logic [5:0]  preload_gain = 6'h00, active_gain, g[4];
  logic [7:0]  preload_offset = 8'h00, data_bus, active_offset, o[4];
  logic [13:0] conv_result = 14'h0000, word, ew, exp_q[$];
  logic        conv_ready, data_bus_oe_n, bus_upper, bus_lower, adc_track, pga_next;
  logic        clamp_to_ground, clamp_to_top_ref, video_track, black_ref_stored;
  logic        bottom_ref_input, ext_ref_subtract, ext_ref_bias_drive, bus_ready, word_stb;
  logic        cc_prev = 1'b0, ls_prev = 1'b0, fall_d = 1'b0, rst_prev = 1'b1, fall, take;
  logic [2:0]  cc_cnt = 3'h0;
  int          err_total = 0, compares = 0, cnt = 0;

  sapseq_top dut (.core_clk, .srst, .conversion_clock, .clamp_strobe, .line_sync, .cfg_load,
    .config_select_high, .config_select_low, .internal_sensor_ref_select, .external_ref_select,
    .preload_we, .preload_colour, .preload_gain, .preload_offset, .conv_result, .conv_valid,
    .conv_ready, .bus_ready, .data_bus, .data_bus_oe_n, .bus_upper, .bus_lower, .adc_track,
    .pga_next, .clamp_to_ground, .clamp_to_top_ref, .video_track, .black_ref_stored,
    .bottom_ref_input, .ext_ref_subtract, .ext_ref_bias_drive, .colour, .active_gain,
    .active_offset);
  sapseq_rx_model rx (.core_clk, .srst, .slow, .data_bus, .data_bus_oe_n, .bus_upper,
    .bus_lower, .bus_ready, .word, .pad, .word_stb);

  always #4 core_clk = ~core_clk;

  // conversion clock of 8 core cycles, random words with full and zero scale among them
  always @(posedge core_clk) begin
    conv_result <= ($urandom % 4 == 0) ? 14'h3FFF :
                   ($urandom % 4 == 0) ? 14'h0000 : 14'($urandom);
    cc_cnt <= srst ? 3'h0 : cc_cnt + 3'h1;
    conversion_clock <= srst ? 1'b0 : cc_cnt[2];
  end

  // buffer model, pixel order and per-cycle timing
  always @(posedge core_clk) begin
    fall = !conversion_clock && cc_prev;
    if (!srst && !rst_prev) begin
      `CHK(adc_track, cc_prev)
      `CHK(pga_next, fall_d)
      `CHK(data_bus_oe_n, ls_prev)
      `CHK(conv_ready, cnt < 2)
    end
    if (word_stb && !srst) begin
      `CHK(exp_q.size() != 0, 1'b1)
      if (exp_q.size() != 0) begin
        ew = exp_q.pop_front();
        `CHK(word, ew)
        `CHK(pad, sapseq_pkg::LOWER_PAD)
      end
    end
    if (srst) begin
      cnt = 0;
      exp_q.delete();
      mode_m <= sapseq_pkg::CFG_RST;
    end else begin
      // a full buffer refuses the word even when it pops on the same edge
      take = fall && cnt < 2 && conv_valid;
      if (fall && cnt > 0 && bus_ready) cnt--;
      if (take) begin
        exp_q.push_back(mode_m == sapseq_pkg::CFG_CCD ? ~conv_result : conv_result);
        cnt++;
      end
      if (cfg_load) mode_m <= {config_select_high, config_select_low};
    end
    cc_prev <= conversion_clock;
    ls_prev <= line_sync;
    fall_d <= fall && !srst;
    rst_prev <= srst;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic set_cfg(input logic [1:0] m, input logic i, input logic e);
    {config_select_high, config_select_low} <= m;
    internal_sensor_ref_select <= i;
    external_ref_select <= e;
    cfg_load <= 1'b1;
    tick(1);
    cfg_load <= 1'b0;
    tick(4);
  endtask

  task automatic stop_test;
    if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge core_clk);
    err_total++;
    stop_test;
  end

  initial begin
    logic       ir, er;
    logic [2:0] seen;
    int         ec;
    void'($urandom(32'h6A436730));
    tick(5);
    srst <= 1'b0;
    tick(3);
    `CHK(bottom_ref_input, 1'b1)
    `CHK(colour, sapseq_pkg::COLOUR_RED)
    `CHK(active_gain, sapseq_pkg::GAIN_RST)
    `CHK(active_offset, sapseq_pkg::OFFS_RST)
    `CHK(ext_ref_subtract | ext_ref_bias_drive | clamp_to_ground, 1'b0)
    conv_valid <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      ir = 1'($urandom);
      er = 1'($urandom);
      set_cfg(2'(m), ir, er);
      `CHK(bottom_ref_input, m == 0 || m == 3)
      `CHK(ext_ref_subtract, er & ~ir)
      `CHK(ext_ref_bias_drive, ir)
      clamp_strobe <= 1'b1;
      tick(3);
      `CHK(clamp_to_ground, m == 1)
      `CHK(clamp_to_top_ref, m == 2)
      `CHK(video_track, 1'b0)
      clamp_strobe <= 1'b0;
      seen = 3'h0;
      repeat (4) begin
        tick(1);
        seen += {2'h0, black_ref_stored};
      end
      `CHK(seen, (m == 1 || m == 2) ? 3'h1 : 3'h0)
      `CHK(video_track, 1'b1)
      slow <= 2'h1;
      tick(120);
      slow <= 2'h2;
      tick(40);
      slow <= 2'h0;
      tick(60);
    end
    conv_valid <= 1'b0;
    tick(60);
    `CHK(exp_q.size(), 0)
    for (int c = 0; c < 4; c++) begin
      g[c] = 6'($urandom);
      o[c] = 8'($urandom);
      preload_colour <= 2'(c);
      preload_gain <= g[c];
      preload_offset <= o[c];
      preload_we <= 1'b1;
      tick(1);
    end
    preload_we <= 1'b0;
    set_cfg(sapseq_pkg::CFG_ROTATE, 1'b0, 1'b0);
    for (int k = 0; k < 6; k++) begin
      if (k == 4) begin
        set_cfg(sapseq_pkg::CFG_SENSOR_DC, 1'b0, 1'b0);
        set_cfg(sapseq_pkg::CFG_ROTATE, 1'b0, 1'b0);
      end
      line_sync <= 1'b1;
      tick(2);
      line_sync <= 1'b0;
      tick(4);
      ec = (k < 4) ? k % 3 : k - 4;
      `CHK(colour, 2'(ec))
      `CHK(active_gain, g[ec])
      `CHK(active_offset, o[ec])
    end
    stop_test;
  end
endmodule // sensor_adc_pixel_sequencer_tb
